/* rtl/ttic_top.sv */
`timescale 1ns/1ps
`default_nettype none
module ttic_top #(
  parameter int PULSE_CYCLES = ttic_pkg::PULSE_CYCLES
) (
  input  wire logic       MCLK,
  input  wire logic       ARST_N,
  input  wire logic       REG_WE,
  input  wire logic [3:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       HOST_ADDRESSED,
  input  wire logic       BUS_BUSY,
  input  wire logic       CONV_DONE,
  input  wire logic [9:0] TEMP_DEG,
  input  wire logic       MAG_THR_CROSS,
  output var  logic [7:0] REG_RDATA,
  output var  logic       TEMP_CH_EN,
  output var  logic       TEMP_RESULT_VALID,
  output var  logic       INT_N,
  output var  logic       SCL_INT_OE
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] temp_cfg_r;
  logic [7:0] int_cfg_r;
  logic       over_r;
  logic       irq_r;
  logic       int_n_r;
  logic       scl_oe_r;
  logic [7:0] rdata_r;
  logic       ch_en_r;
  logic       valid_r;
  ttic_pkg::ttic_wr_t wr;

  assign wr = '{we: REG_WE, addr: REG_ADDR, wdata: REG_WDATA};

  // threshold code storage, channel enable bit
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      temp_cfg_r <= ttic_pkg::TEMPERATURE_CONFIG_RST;
    end else if (wr.we && wr.addr == ttic_pkg::TEMPERATURE_CONFIG_OFS) begin
      temp_cfg_r <= wr.wdata;
    end
  end

  // Reserved bit 1 stays zero
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      int_cfg_r <= ttic_pkg::INTERRUPT_CONFIG_RST;
    end else if (wr.we && wr.addr == ttic_pkg::INTERRUPT_CONFIG_OFS) begin
      int_cfg_r <= wr.wdata & ttic_pkg::INT_CFG_RO_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Read-back
  // ----------------------------------------------------------------
  // Registered so the read port leaves a flip-flop; costs one cycle
  // Unmapped offsets read as zero

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_r <= 8'h00;
    end else begin
      case (REG_ADDR)
        ttic_pkg::TEMPERATURE_CONFIG_OFS: rdata_r <= temp_cfg_r;
        ttic_pkg::INTERRUPT_CONFIG_OFS:   rdata_r <= int_cfg_r;
        default:                          rdata_r <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Temperature threshold
  // ----------------------------------------------------------------
  logic [6:0] code;
  logic [9:0] thr_deg;
  logic       cmp_on;
  logic       above;
  logic       temp_cross;

  assign code = temp_cfg_r[ttic_pkg::TEMP_CODE_MSB:ttic_pkg::TEMP_CODE_LSB];
  assign thr_deg = {3'h0, code} << ttic_pkg::TEMP_STEP_SHIFT;
  assign cmp_on = (code != ttic_pkg::TEMP_CODE_OFF) && temp_cfg_r[ttic_pkg::TEMP_CH_EN_BIT];
  assign above  = cmp_on && CONV_DONE && (TEMP_DEG >= thr_deg);
  assign temp_cross = above && !over_r;

  // Crossing is an upward edge, re-armed when reading falls below
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      over_r <= 1'b0;
    end else if (!cmp_on) begin
      over_r <= 1'b0;
    end else if (CONV_DONE) begin
      over_r <= (TEMP_DEG >= thr_deg);
    end
  end

  // ----------------------------------------------------------------
  // Temperature channel
  // ----------------------------------------------------------------
  // Validity drops at once when the channel turns off

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ch_en_r <= 1'b0;
      valid_r <= 1'b0;
    end else begin
      ch_en_r <= temp_cfg_r[ttic_pkg::TEMP_CH_EN_BIT];
      if (!temp_cfg_r[ttic_pkg::TEMP_CH_EN_BIT]) begin
        valid_r <= 1'b0;
      end else if (CONV_DONE) begin
        valid_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt events
  // ----------------------------------------------------------------
  logic event_hit;
  logic pulse_mode;
  logic pulse_busy;

  assign event_hit = (int_cfg_r[ttic_pkg::CONV_IRQ_EN_BIT] && CONV_DONE) ||
                     (int_cfg_r[ttic_pkg::THR_IRQ_EN_BIT] && (temp_cross || MAG_THR_CROSS));
  assign pulse_mode = int_cfg_r[ttic_pkg::PULSE_SEL_BIT];

  // ----------------------------------------------------------------
  // Pulse timer
  // ----------------------------------------------------------------
  // A new event while busy restarts the full length

  ttic_pulse #(.CYCLES(PULSE_CYCLES)) u_pulse (
    .clk    (MCLK),
    .arst_n (ARST_N),
    .start  (event_hit && pulse_mode),
    .busy   (pulse_busy)
  );

  // ----------------------------------------------------------------
  // Latched interrupt
  // ----------------------------------------------------------------
  // Clear reaches the pin two edges after the address pulse

  // latch until addressed; a new event beats the clear
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_r <= 1'b0;
    end else if (pulse_mode) begin
      irq_r <= 1'b0;
    end else if (event_hit) begin
      irq_r <= 1'b1;
    end else if (HOST_ADDRESSED) begin
      irq_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Routing
  // ----------------------------------------------------------------
  logic       asserted;
  logic [2:0] route;

  assign asserted = pulse_mode ? (pulse_busy || (event_hit)) : (irq_r || event_hit);
  assign route = int_cfg_r[ttic_pkg::ROUTE_MSB:ttic_pkg::ROUTE_LSB];

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      int_n_r  <= 1'b1;
      scl_oe_r <= 1'b0;
    end else begin
      int_n_r  <= 1'b1;
      scl_oe_r <= 1'b0;
      case (route)
        ttic_pkg::ROUTE_PIN: begin
          int_n_r <= !(asserted && !int_cfg_r[ttic_pkg::PIN_MASK_BIT]);
        end
        ttic_pkg::ROUTE_PIN_IDLE: begin
          int_n_r <= !(asserted && !BUS_BUSY && !int_cfg_r[ttic_pkg::PIN_MASK_BIT]);
        end
        ttic_pkg::ROUTE_SCL: begin
          scl_oe_r <= asserted;
        end
        ttic_pkg::ROUTE_SCL_IDLE: begin
          scl_oe_r <= asserted && !BUS_BUSY;
        end
        default: begin
          int_n_r  <= 1'b1;
          scl_oe_r <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  assign REG_RDATA         = rdata_r;
  assign TEMP_CH_EN        = ch_en_r;
  assign TEMP_RESULT_VALID = valid_r;
  assign INT_N             = int_n_r;
  assign SCL_INT_OE        = scl_oe_r;

endmodule : ttic_top
`default_nettype wire

/* pkg/ttic_pkg.sv */
package ttic_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] TEMPERATURE_CONFIG_OFS = 4'h7;
  localparam logic [3:0] INTERRUPT_CONFIG_OFS   = 4'h8;
  localparam logic [7:0] TEMPERATURE_CONFIG_RST = 8'h00;
  localparam logic [7:0] INTERRUPT_CONFIG_RST   = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TEMP_CODE_MSB      = 7;
  localparam int TEMP_CODE_LSB      = 1;
  localparam int TEMP_CH_EN_BIT     = 0;
  localparam int CONV_IRQ_EN_BIT    = 7;
  localparam int THR_IRQ_EN_BIT     = 6;
  localparam int PULSE_SEL_BIT      = 5;
  localparam int ROUTE_MSB          = 4;
  localparam int ROUTE_LSB          = 2;
  localparam int PIN_MASK_BIT       = 0;
  localparam logic [7:0] INT_CFG_RO_MASK = 8'hFD;

  // ----------------------------------------------------------------
  // Threshold code scaling: code * 8 C, no offset, so 1Ah -> 208 C
  // ----------------------------------------------------------------
  localparam logic [6:0] TEMP_CODE_OFF  = 7'h00;
  localparam logic [6:0] TEMP_CODE_MIN  = 7'h1A;
  localparam logic [6:0] TEMP_CODE_MAX  = 7'h34;
  localparam int         TEMP_STEP_SHIFT = 3;

  // ----------------------------------------------------------------
  // Interrupt routing codes
  // ----------------------------------------------------------------
  localparam logic [2:0] ROUTE_NONE     = 3'h0;
  localparam logic [2:0] ROUTE_PIN      = 3'h1;
  localparam logic [2:0] ROUTE_PIN_IDLE = 3'h2;
  localparam logic [2:0] ROUTE_SCL      = 3'h3;
  localparam logic [2:0] ROUTE_SCL_IDLE = 3'h4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS  = 25000;
  localparam int PULSE_TIME_NS  = 10000;
  localparam int PULSE_CYCLES   = (PULSE_TIME_NS * 1000) / CLK_PERIOD_PS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       we;
    logic [3:0] addr;
    logic [7:0] wdata;
  } ttic_wr_t;

  typedef struct packed {
    logic       conv_done;
    logic       temp_valid;
    logic [9:0] temp_deg;
  } ttic_meas_t;

endpackage : ttic_pkg

/* rtl/ttic_pulse.sv */
`timescale 1ns/1ps
`default_nettype none
module ttic_pulse #(
  parameter int CYCLES = ttic_pkg::PULSE_CYCLES
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic start,
  output var  logic busy
);
  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt_r;

  // Fixed-length pulse timer, restarts on a new event
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
    end else if (start) begin
      cnt_r <= CW'(CYCLES);
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - CW'(1);
    end
  end

  assign busy = (cnt_r != '0);
endmodule : ttic_pulse
`default_nettype wire

/* verif/ttic_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module ttic_properties #(
  parameter int PULSE_CYCLES = 8
) (
  input wire logic       MCLK,
  input wire logic       ARST_N,
  input wire logic       REG_WE,
  input wire logic [3:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic       HOST_ADDRESSED,
  input wire logic       CONV_DONE,
  input wire logic       MAG_THR_CROSS,
  input wire logic [7:0] REG_RDATA,
  input wire logic       TEMP_CH_EN,
  input wire logic       INT_N,
  input wire logic       SCL_INT_OE
);
  localparam int PMAX = PULSE_CYCLES + 2;
  logic [7:0] tc_r;
  logic [7:0] ic_r;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  // Shadow of the two registers, fed only by bus writes
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tc_r <= 8'h00;
      ic_r <= 8'h00;
    end else if (REG_WE && REG_ADDR == 4'h7) begin
      tc_r <= REG_WDATA;
    end else if (REG_WE && REG_ADDR == 4'h8) begin
      ic_r <= REG_WDATA & 8'hFD;
    end
  end
  sequence addr_clear;
    !INT_N && !ic_r[5] && HOST_ADDRESSED && !REG_WE && !CONV_DONE && !MAG_THR_CROSS;
  endsequence
  sequence quiet_cycle;
    !CONV_DONE && !MAG_THR_CROSS;
  endsequence
  sequence held_low;
    !INT_N [*6];
  endsequence
  chk_rd_temp: assert property (REG_ADDR == 4'h7 |=> REG_RDATA == $past(tc_r))
    else $error("temperature readback wrong");
  chk_rd_int: assert property (REG_ADDR == 4'h8 |=> REG_RDATA == $past(ic_r))
    else $error("interrupt readback wrong");
  chk_chan_en: assert property (tc_r[0] == $past(tc_r[0]) |-> TEMP_CH_EN == tc_r[0])
    else $error("channel enable wrong");
  chk_conv_irq: assert property (CONV_DONE && ic_r == 8'h84 |=> !INT_N)
    else $error("done irq missing");
  chk_latch_hold: assert property (!INT_N && !ic_r[5] && !HOST_ADDRESSED && !REG_WE
    && !$past(HOST_ADDRESSED) && !$past(REG_WE) |=> !INT_N)
    else $error("latch dropped");
  chk_host_clr: assert property (addr_clear ##1 quiet_cycle |=> INT_N)
    else $error("latch not cleared");
  chk_pulse_len: assert property ($fell(INT_N) && ic_r[5] |-> held_low ##[1:PMAX] INT_N)
    else $error("pulse length wrong");
  chk_scl_route: assert property (CONV_DONE && ic_r == 8'h8C |=> SCL_INT_OE && INT_N)
    else $error("clock line route wrong");
endmodule : ttic_properties
bind ttic_top ttic_properties #(.PULSE_CYCLES(PULSE_CYCLES)) i_chk (.*);
`default_nettype wire

/* verif/ttic_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ttic_host_model (
  input  wire logic       clk,
  input  wire logic       irq,
  input  wire logic       en,
  input  wire logic [3:0] dly,
  output var  logic       host_addressed
);
  int cnt = 0;
  initial host_addressed = 1'b0;
  always @(negedge clk) begin
    host_addressed <= (irq === 1'b1) && en && (cnt + 1 == int'(dly));
    cnt = (irq === 1'b1 && en && cnt + 1 != int'(dly)) ? cnt + 1 : 0;
  end
endmodule : ttic_host_model
`default_nettype wire

/* verif/tb_temp_threshold_irq_config.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_temp_threshold_irq_config;
  logic       MCLK = 1'b0, ARST_N = 1'b0, REG_WE = 1'b0, CONV_DONE = 1'b0;
  logic       MAG_THR_CROSS = 1'b0, BUS_BUSY = 1'b0, host_en = 1'b1, HOST_ADDRESSED;
  logic [3:0] REG_ADDR = 4'h0, dly = 4'h3;
  logic [7:0] REG_WDATA = 8'h00, REG_RDATA;
  logic [9:0] TEMP_DEG = 10'h000;
  logic       TEMP_CH_EN, TEMP_RESULT_VALID, INT_N, SCL_INT_OE;
  int         failures = 0, samples_checked = 0, code, r;
  localparam int PULSE_CYC = 8;
  always #12.5 MCLK = ~MCLK;
  ttic_top #(.PULSE_CYCLES(PULSE_CYC)) i_dut (.MCLK(MCLK), .ARST_N(ARST_N), .REG_WE(REG_WE),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .HOST_ADDRESSED(HOST_ADDRESSED),
    .BUS_BUSY(BUS_BUSY), .CONV_DONE(CONV_DONE), .TEMP_DEG(TEMP_DEG),
    .MAG_THR_CROSS(MAG_THR_CROSS), .REG_RDATA(REG_RDATA), .TEMP_CH_EN(TEMP_CH_EN),
    .TEMP_RESULT_VALID(TEMP_RESULT_VALID), .INT_N(INT_N), .SCL_INT_OE(SCL_INT_OE));
  ttic_host_model i_host (.clk(MCLK), .irq(!INT_N || SCL_INT_OE), .en(host_en), .dly(dly),
    .host_addressed(HOST_ADDRESSED));
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge MCLK);
    {REG_WE, REG_ADDR, REG_WDATA} = {1'b1, a, d};
    @(negedge MCLK);
    REG_WE = 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(negedge MCLK);
    REG_ADDR = a;
    repeat (2) @(negedge MCLK);
    chk(REG_RDATA, e);
  endtask : rd
  task automatic ev(input logic c, input logic m, input logic [9:0] t);
    @(negedge MCLK);
    {CONV_DONE, MAG_THR_CROSS, TEMP_DEG} = {c, m, t};
    @(negedge MCLK);
    {CONV_DONE, MAG_THR_CROSS} = 2'b00;
    @(negedge MCLK);
  endtask : ev
  task automatic report_and_stop;
    $display("checks=%0d failures=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    r = $urandom(32'hd560);
    repeat (8) @(negedge MCLK);
    ARST_N = 1'b1;
    rd(4'h7, 8'h00);
    rd(4'h8, 8'h00);
    wr(4'h8, 8'hFF);
    rd(4'h8, 8'hFD);
    rd(4'h3, 8'h00);
    for (r = 0; r < 8; r++) begin
      // Pulse mode first, so no latch from an unrouted code survives
      wr(4'h8, 8'h20);
      wr(4'h8, {3'b100, r[2:0], 2'b00});
      dly = 4'h2 + 4'($urandom_range(0, 4));
      ev(1'b1, 1'b0, 10'h000);
      chk(INT_N, r != 1 && r != 2);
      chk(SCL_INT_OE, r == 3 || r == 4);
      repeat (10) @(negedge MCLK);
      chk({INT_N, SCL_INT_OE}, 2'b10);
    end
    wr(4'h8, 8'h20);
    wr(4'h8, 8'h88);
    BUS_BUSY = 1'b1;
    ev(1'b1, 1'b0, 10'h000);
    chk(INT_N, 1'b1);
    BUS_BUSY = 1'b0;
    @(negedge MCLK);
    chk(INT_N, 1'b0);
    repeat (10) @(negedge MCLK);
    wr(4'h8, 8'h85);
    ev(1'b1, 1'b0, 10'h000);
    chk(INT_N, 1'b1);
    wr(4'h8, 8'h04);
    repeat (10) @(negedge MCLK);
    code = 8'h1A + $urandom_range(0, 26);
    wr(4'h7, {code[6:0], 1'b1});
    wr(4'h8, 8'h44);
    rd(4'h7, {code[6:0], 1'b1});
    chk(TEMP_CH_EN, 1'b1);
    ev(1'b1, 1'b0, 10'(code * 8 - 1));
    chk({INT_N, TEMP_RESULT_VALID}, 2'b11);
    ev(1'b1, 1'b0, 10'(code * 8));
    chk(INT_N, 1'b0);
    repeat (10) @(negedge MCLK);
    ev(1'b0, 1'b1, 10'h000);
    chk(INT_N, 1'b0);
    repeat (10) @(negedge MCLK);
    wr(4'h7, 8'h01);
    ev(1'b1, 1'b0, 10'h000);
    ev(1'b1, 1'b0, 10'h3FF);
    chk(INT_N, 1'b1);
    wr(4'h7, 8'h00);
    @(negedge MCLK);
    chk({TEMP_CH_EN, TEMP_RESULT_VALID}, 2'b00);
    host_en = 1'b0;
    wr(4'h8, 8'hA4);
    ev(1'b1, 1'b0, 10'h000);
    chk(INT_N, 1'b0);
    for (r = 0; r < 20 && INT_N !== 1'b1; r++) @(negedge MCLK);
    chk(10'(r), 10'(PULSE_CYC));
    report_and_stop();
  end
endmodule : tb_temp_threshold_irq_config
`default_nettype wire
